// [inc/health_defs.svh]
// constants for the satellite health decoder and power-up self-test
// assumes a 100 MHz system clock and an active-low asynchronous reset
`ifndef HEALTH_DEFS_SVH
`define HEALTH_DEFS_SVH

`define HEALTH_BYTE_W      8
`define HEALTH_DATA_MSB    7
`define HEALTH_DATA_LSB    5
`define HEALTH_SIG_MSB     4
`define HEALTH_SIG_LSB     0
`define HEALTH_SIG_SPARE   5'h1E
`define HEALTH_SIG_UNDEF   5'h1F
`define HEALTH_SIG_NONE    5'h1F
`define SELFTEST_TIMEOUT_NS    1000
`define SELFTEST_TIMEOUT_CYC   (`SELFTEST_TIMEOUT_NS / 10)
`define SCREEN_INITIAL     4'h0
`define SCREEN_W           4

`endif

// [inc/health_pkg.sv]
// types for the satellite health decoder and self-test sequencer
// assumes health_defs.svh supplies the numeric constants
package health_pkg;

    typedef enum logic [2:0] {
        DATA_ALL_GOOD,
        DATA_PARITY_FAIL,
        DATA_TLM_HOW_FORMAT,
        DATA_HOW_ZCOUNT_BAD,
        DATA_SF123_BAD,
        DATA_SF45_BAD,
        DATA_UPLOAD_BAD,
        DATA_ALL_BAD
    } data_health_type;

    typedef enum logic [2:0] {
        STEP_IDLE,
        STEP_PROGRAM_SUM,
        STEP_EXPANSION_BOARD,
        STEP_MAGVAR_SUM,
        STEP_DOWNLOAD,
        STEP_RUN,
        STEP_HALT
    } selftest_type;

endpackage

// [verilog/sat_health_code_decoder.sv]
// satellite health code decoder with power-up self-test sequencer
// assumes health digits and self-test results come from same-clock logic
`timescale 1ns/1ps
`include "health_defs.svh"

module sat_health_code_decoder (
    input  wire logic       I_MCLK,
    input  wire logic       I_RESET_N,
    input  wire logic [3:0] I_DIGIT_HI,
    input  wire logic [3:0] I_DIGIT_LO,
    input  wire logic       I_CODE_VALID,
    input  wire logic       I_TEST_DONE,
    input  wire logic       I_TEST_PASS,
    input  wire logic       I_DOWNLOAD_DONE,
    output logic [2:0]      O_DATA_CLASS,
    output logic [4:0]      O_SIGNAL_CLASS,
    output logic            O_SIGNAL_SPARE,
    output logic            O_SIGNAL_UNDEF,
    output logic            O_CLASS_VALID,
    output logic [2:0]      O_TEST_STEP,
    output logic            O_TEST_START,
    output logic            O_TEST_REPORT,
    output logic            O_TEST_PASS,
    output logic            O_HALTED,
    output logic            O_DOWNLOADING,
    output logic            O_RUNNING,
    output logic [3:0]      O_SCREEN
);

    ////////////////////////////////////////////////////////////////////
    // decode: the class codes equal the field values, so the tables
    // map one to one; spare and undefined codes are flagged apart
    wire [7:0] health_byte = {I_DIGIT_HI, I_DIGIT_LO};
    // bit 0 of the field numbering is byte bit 7
    wire [2:0] data_field =
        health_byte[`HEALTH_DATA_MSB:`HEALTH_DATA_LSB];
    wire [4:0] sig_field =
        health_byte[`HEALTH_SIG_MSB:`HEALTH_SIG_LSB];
    // 000..111 in order
    wire [2:0] data_class = data_field;
    // 00000..11101 in order
    wire       sig_spare = (sig_field == `HEALTH_SIG_SPARE);
    wire       sig_undef = (sig_field == `HEALTH_SIG_UNDEF);

    always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_DATA_CLASS   <= 3'h0;
            O_SIGNAL_CLASS <= 5'h00;
            O_SIGNAL_SPARE <= 1'b0;
            O_SIGNAL_UNDEF <= 1'b0;
            O_CLASS_VALID  <= 1'b0;
        end else begin
            O_CLASS_VALID <= I_CODE_VALID;
            if (I_CODE_VALID) begin
                O_DATA_CLASS   <= data_class;
                O_SIGNAL_CLASS <= sig_field;
                O_SIGNAL_SPARE <= sig_spare;
                O_SIGNAL_UNDEF <= sig_undef;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // self-test sequencer
    health_pkg::selftest_type step;
    health_pkg::selftest_type next_step;

    wire testing = (step == health_pkg::STEP_PROGRAM_SUM) ||
                   (step == health_pkg::STEP_EXPANSION_BOARD) ||
                   (step == health_pkg::STEP_MAGVAR_SUM);
    wire result_in = testing && I_TEST_DONE;
    wire failed    = result_in && !I_TEST_PASS;

    always_comb begin
        next_step = step;
        unique case (step)
            health_pkg::STEP_IDLE:
                next_step = health_pkg::STEP_PROGRAM_SUM;
            health_pkg::STEP_PROGRAM_SUM:
                if (result_in) begin
                    next_step = failed ? health_pkg::STEP_HALT
                                       : health_pkg::STEP_EXPANSION_BOARD;
                end
            health_pkg::STEP_EXPANSION_BOARD:
                if (result_in) begin
                    next_step = failed ? health_pkg::STEP_HALT
                                       : health_pkg::STEP_MAGVAR_SUM;
                end
            health_pkg::STEP_MAGVAR_SUM:
                if (result_in) begin
                    next_step = failed ? health_pkg::STEP_HALT
                                       : health_pkg::STEP_DOWNLOAD;
                end
            health_pkg::STEP_DOWNLOAD:
                if (I_DOWNLOAD_DONE) begin
                    next_step = health_pkg::STEP_RUN;
                end
            health_pkg::STEP_RUN:  next_step = step;
            health_pkg::STEP_HALT: next_step = step;
            default:               next_step = health_pkg::STEP_HALT;
        endcase
    end

    wire entering_test = (next_step != step) &&
        ((next_step == health_pkg::STEP_PROGRAM_SUM) ||
         (next_step == health_pkg::STEP_EXPANSION_BOARD) ||
         (next_step == health_pkg::STEP_MAGVAR_SUM));

    always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            step          <= health_pkg::STEP_IDLE;
            O_TEST_STEP   <= 3'h0;
            O_TEST_START  <= 1'b0;
            O_TEST_REPORT <= 1'b0;
            O_TEST_PASS   <= 1'b0;
            O_HALTED      <= 1'b0;
            O_DOWNLOADING <= 1'b0;
            O_RUNNING     <= 1'b0;
            O_SCREEN      <= `SCREEN_INITIAL;
        end else begin
            step          <= next_step;
            O_TEST_START  <= entering_test;
            O_TEST_REPORT <= result_in;
            // halted step keeps its indication
            if (testing) begin
                O_TEST_STEP <= step;
            end
            if (result_in) begin
                O_TEST_PASS <= I_TEST_PASS;
            end
            O_HALTED      <= (next_step == health_pkg::STEP_HALT);
            O_DOWNLOADING <= (next_step == health_pkg::STEP_DOWNLOAD);
            O_RUNNING     <= (next_step == health_pkg::STEP_RUN);
            if (next_step == health_pkg::STEP_RUN) begin
                O_SCREEN <= `SCREEN_INITIAL;
            end
        end
    end

endmodule

// [test/health_source.sv]
// partner model: tracking logic handing the health byte over as two digits
// assumes the bench sets code and send just after a falling clock edge
`timescale 1ns/1ps
module health_source (
    input  wire logic       clk,
    input  wire logic [7:0] code,
    input  wire logic       send,
    output logic [3:0]      digit_hi,
    output logic [3:0]      digit_lo,
    output logic            code_valid
);
    logic [7:0] last = 8'h00;
    always @(posedge clk) if (send) last <= code;
    // idle digits show the inverse of the last byte, not a held copy
    assign code_valid = send;
    assign digit_hi   = send ? code[7:4] : ~last[7:4];
    assign digit_lo   = send ? code[3:0] : ~last[3:0];
endmodule

// [test/health_checker_properties.sv]
// checker: decode and self-test timing seen at the decoder ports
// assumes one clock domain with an asynchronous active-low reset
`timescale 1ns/1ps
module health_checker (
    input wire logic       I_MCLK,
    input wire logic       I_RESET_N,
    input wire logic [3:0] I_DIGIT_HI,
    input wire logic [3:0] I_DIGIT_LO,
    input wire logic       I_CODE_VALID,
    input wire logic       I_TEST_DONE,
    input wire logic [2:0] O_DATA_CLASS,
    input wire logic [4:0] O_SIGNAL_CLASS,
    input wire logic       O_SIGNAL_SPARE,
    input wire logic       O_SIGNAL_UNDEF,
    input wire logic       O_CLASS_VALID,
    input wire logic [2:0] O_TEST_STEP,
    input wire logic       O_TEST_START,
    input wire logic       O_TEST_REPORT,
    input wire logic       O_TEST_PASS,
    input wire logic       O_HALTED,
    input wire logic       O_DOWNLOADING,
    input wire logic       O_RUNNING
);
    default clocking @(posedge I_MCLK); endclocking
    default disable iff (!I_RESET_N);
    data_field_a: assert property (I_CODE_VALID |=> O_CLASS_VALID &&
        O_DATA_CLASS == $past(I_DIGIT_HI[3:1])) else $error("data class");
    signal_field_a: assert property (I_CODE_VALID |=>
        O_SIGNAL_CLASS == $past({I_DIGIT_HI[0], I_DIGIT_LO}))
        else $error("signal class");
    spare_flag_a: assert property (O_CLASS_VALID |->
        O_SIGNAL_SPARE == (O_SIGNAL_CLASS == 5'h1E)) else $error("spare");
    undef_flag_a: assert property (O_CLASS_VALID |->
        O_SIGNAL_UNDEF == (O_SIGNAL_CLASS == 5'h1F)) else $error("undef");
    test_report_a: assert property (O_TEST_START && I_TEST_DONE |=>
        O_TEST_REPORT) else $error("no report");
    fail_halt_a: assert property (O_TEST_REPORT && !O_TEST_PASS |->
        O_HALTED[*3]) else $error("no halt");
    halt_hold_a: assert property (O_HALTED |=> O_HALTED && !O_RUNNING &&
        !O_TEST_START && $stable(O_TEST_STEP)) else $error("halt left");
    run_order_a: assert property ($rose(O_RUNNING) |->
        $past(O_DOWNLOADING) && !O_DOWNLOADING) else $error("run order");
    cover property (O_RUNNING);
    cover property (O_HALTED);
    cover property (O_CLASS_VALID && O_SIGNAL_UNDEF);
endmodule
bind sat_health_code_decoder health_checker i_chk (.*);

// [test/sat_health_code_decoder_tb_top.sv]
// testbench: full decode sweep, self-test pass path and fail path
// assumes the design, checker and health_source are compiled first
`timescale 1ns/1ps
module sat_health_code_decoder_tb_top;
    logic I_MCLK = 0, I_RESET_N = 0, I_CODE_VALID, I_TEST_DONE = 0, send = 0;
    logic I_TEST_PASS = 0, I_DOWNLOAD_DONE = 0, O_SIGNAL_SPARE, O_SIGNAL_UNDEF;
    logic O_CLASS_VALID, O_TEST_START, O_TEST_REPORT, O_TEST_PASS, O_HALTED;
    logic O_DOWNLOADING, O_RUNNING;
    logic [3:0] I_DIGIT_HI, I_DIGIT_LO, O_SCREEN;
    logic [2:0] O_DATA_CLASS, O_TEST_STEP;
    logic [4:0] O_SIGNAL_CLASS;
    logic [7:0] code = 8'h00;
    int bad_count = 0, checks = 0;
    always #5 I_MCLK = ~I_MCLK;
    sat_health_code_decoder i_dut (.*);
    health_source i_src (.clk(I_MCLK), .code(code), .send(send),
        .digit_hi(I_DIGIT_HI), .digit_lo(I_DIGIT_LO), .code_valid(I_CODE_VALID));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic restart();
        I_RESET_N = 0;
        repeat (5) @(negedge I_MCLK);
        I_RESET_N = 1;
    endtask
    task automatic run_step(input logic pass, input logic [2:0] step);
        I_TEST_PASS = pass;
        I_TEST_DONE = 1;
        @(negedge I_MCLK);
        I_TEST_DONE = 0;
        check("report", O_TEST_REPORT, 1);
        check("result", O_TEST_PASS, pass);
        check("step", O_TEST_STEP, step);
        @(negedge I_MCLK);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic test_decode();
        for (int b = 0; b < 256; b++) begin
            code = 8'(b);
            send = 1;
            @(negedge I_MCLK);
            check("valid", O_CLASS_VALID, 1);
            check("data", O_DATA_CLASS, code[7:5]);
            check("signal", O_SIGNAL_CLASS, code[4:0]);
            check("spare", O_SIGNAL_SPARE, code[4:0] == 5'h1E);
            check("undef", O_SIGNAL_UNDEF, code[4:0] == 5'h1F);
        end
        send = 0;
        $display("decode sweep done");
    endtask
    task automatic test_pass();
        restart();
        @(negedge I_MCLK);
        check("start", O_TEST_START, 1);
        for (int s = 1; s < 4; s++)
            run_step(1'b1, 3'(s));
        check("download", O_DOWNLOADING, 1);
        I_DOWNLOAD_DONE = 1;
        @(negedge I_MCLK);
        I_DOWNLOAD_DONE = 0;
        check("running", {O_RUNNING, O_DOWNLOADING, O_SCREEN}, 8'h20);
        $display("self-test pass path done");
    endtask
    task automatic test_fail();
        restart();
        @(negedge I_MCLK);
        run_step(1'b1, 3'h1);
        run_step(1'b0, 3'h2);
        I_TEST_PASS = 1;
        I_TEST_DONE = 1;
        I_DOWNLOAD_DONE = 1;
        @(negedge I_MCLK);
        I_TEST_DONE = 0;
        I_DOWNLOAD_DONE = 0;
        @(negedge I_MCLK);
        check("halt", {O_HALTED, O_RUNNING, O_TEST_STEP}, 8'h12);
        $display("self-test fail path done");
    endtask
    initial begin
        restart();
        test_decode();
        test_pass();
        test_fail();
        finish_test();
    end
endmodule
